// ===== picture_adjust_controls.v
// Picture adjustment pipeline with its control registers on classic Wishbone
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
`include "picture_adjust_defs.vh"
module picture_adjust_controls #(
	parameter LINE_DEPTH = 1024,
	parameter LINE_AW = 10
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// Incoming pixels, chroma offset by 128
	input wire pix_valid,
	input wire line_start,
	input wire [7:0] pix_y,
	input wire [7:0] pix_cb,
	input wire [7:0] pix_cr,
	// Adjusted pixels
	output reg out_valid,
	output reg [7:0] out_y,
	output reg [7:0] out_cb,
	output reg [7:0] out_cr
);

	// ==========================================================
	// Register file state
	reg [6:0] bright_r;
	reg [7:0] luma_contrast_gain_r;
	reg [7:0] chroma_hue_phase_r;
	reg [7:0] luma_band_sharpness_r;
	reg [7:0] chroma_saturation_gain_r;
	reg luma_clip_r;
	reg chroma_clip_r;

	// Bus decode
	wire bus_req;
	wire adr_ok;
	wire [2:0] reg_idx;
	wire wr_lane0;
	reg [7:0] rd_byte;

	// Pipeline state
	reg [7:0] ya_r;
	reg [LINE_AW-1:0] col_r;
	reg [LINE_AW-1:0] col_a_r;
	reg [7:0] w0_r;
	reg [7:0] w1_r;
	reg [7:0] w2_r;
	reg [7:0] w3_r;
	reg [7:0] w4_r;
	reg [7:0] up1_r;
	reg [7:0] up2_r;
	reg [7:0] cb_s_r;
	reg [7:0] cr_s_r;
	reg [7:0] cb_d1_r;
	reg [7:0] cr_d1_r;
	reg [7:0] cb_d2_r;
	reg [7:0] cr_d2_r;
	reg [2:0] fill_r;

	// Pipeline combinational terms
	wire [LINE_AW-1:0] col_in;
	wire signed [9:0] bright_sum;
	wire [7:0] bright_clip;
	wire [15:0] contrast_prod;
	wire [8:0] contrast_shift;
	wire [7:0] contrast_clip;
	wire contrast_over;
	wire [7:0] up0;
	wire signed [10:0] cb_rot;
	wire signed [10:0] cr_rot;
	wire signed [19:0] cb_prod;
	wire signed [19:0] cr_prod;
	wire [7:0] cb_sat;
	wire [7:0] cr_sat;
	wire cb_over;
	wire cr_over;
	wire [10:0] low_sum;
	wire [9:0] med_sum;
	wire [7:0] low_band;
	wire [7:0] med_band;
	wire signed [9:0] low_s;
	wire signed [9:0] mid_s;
	wire signed [9:0] high_s;
	wire [8:0] vert_sum;
	wire signed [9:0] vhf_s;
	wire signed [14:0] sharp_total;
	wire [7:0] sharp_clip;
	wire sharp_over;
	// ==========================================================
	// Helper functions

	// Band gain: shift by code, code 11 drops the band entirely
	function signed [12:0] band_gain;
		input signed [9:0] x;
		input [1:0] code;
		begin
			case (code)
				`PA_GAIN_X1: band_gain = {{3{x[9]}}, x};
				`PA_GAIN_X2: band_gain = {{2{x[9]}}, x, 1'b0};
				`PA_GAIN_X4: band_gain = {x[9], x, 2'b00};
				default: band_gain = 13'h0000;
			endcase
		end
	endfunction

	// Saturate a signed chroma product back to offset-binary 8 bits
	function [7:0] chroma_clip;
		input signed [19:0] p;
		reg signed [12:0] q;
		begin
			q = p[19:7];
			if (q > 13'sd127)
				chroma_clip = 8'hff;
			else if (q < -13'sd128)
				chroma_clip = 8'h00;
			else
				chroma_clip = q[7:0] ^ 8'h80;
		end
	endfunction

	// Overflow test matching the clip above
	function chroma_over;
		input signed [19:0] p;
		reg signed [12:0] q;
		begin
			q = p[19:7];
			chroma_over = (q > 13'sd127) || (q < -13'sd128);
		end
	endfunction
	// ==========================================================
	// Wishbone decode
	assign bus_req = cyc_i & stb_i;
	assign adr_ok = (adr_i[1:0] == 2'h0) && (adr_i[7:5] == 3'h0);
	assign reg_idx = adr_i[4:2];
	// Registers are one byte wide, so only lane 0 can write them
	assign wr_lane0 = bus_req & we_i & ~ack_o & adr_ok & sel_i[0];

	// Read mux; unmapped words answer with zero
	always @* begin
		rd_byte = 8'h00;
		if (adr_ok) begin
			case (reg_idx)
				`PA_IDX_BRIGHT: rd_byte = {1'b0, bright_r};
				`PA_IDX_CONTRAST: rd_byte = luma_contrast_gain_r;
				`PA_IDX_HUE: rd_byte = chroma_hue_phase_r;
				`PA_IDX_SHARP: rd_byte = luma_band_sharpness_r;
				`PA_IDX_SAT: rd_byte = chroma_saturation_gain_r;
				`PA_IDX_STATUS: rd_byte = {6'h00, chroma_clip_r, luma_clip_r};
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// One wait state: ack rises the cycle after the request, then drops
	always @(posedge sys_clk) begin
		if (reset) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req & ~ack_o;
			if (bus_req & ~ack_o & ~we_i)
				dat_o <= {24'h00_0000, rd_byte};
		end
	end
	// ==========================================================
	// Control registers
	always @(posedge sys_clk) begin
		if (reset) begin
			bright_r <= `PA_RST_BRIGHT;
			luma_contrast_gain_r <= `PA_RST_CONTRAST;
			chroma_hue_phase_r <= `PA_RST_HUE;
			luma_band_sharpness_r <= `PA_RST_SHARP;
			chroma_saturation_gain_r <= `PA_RST_SAT;
		end else if (wr_lane0) begin
			case (reg_idx)
				`PA_IDX_BRIGHT: bright_r <= dat_i[6:0];
				`PA_IDX_CONTRAST: luma_contrast_gain_r <= dat_i[7:0];
				`PA_IDX_HUE: chroma_hue_phase_r <= dat_i[7:0];
				`PA_IDX_SHARP: luma_band_sharpness_r <= dat_i[7:0];
				`PA_IDX_SAT: chroma_saturation_gain_r <= dat_i[7:0];
				default: bright_r <= bright_r;
			endcase
		end
	end

	// Sticky clip flags, write one to clear; a new clip beats the clear
	always @(posedge sys_clk) begin
		if (reset) begin
			luma_clip_r <= 1'b0;
			chroma_clip_r <= 1'b0;
		end else begin
			if (pix_valid & (contrast_over | sharp_over))
				luma_clip_r <= 1'b1;
			else if (wr_lane0 && reg_idx == `PA_IDX_STATUS && dat_i[`PA_STAT_LUMA_CLIP])
				luma_clip_r <= 1'b0;
			if (pix_valid & (cb_over | cr_over))
				chroma_clip_r <= 1'b1;
			else if (wr_lane0 && reg_idx == `PA_IDX_STATUS && dat_i[`PA_STAT_CHROMA_CLIP])
				chroma_clip_r <= 1'b0;
		end
	end
	// ==========================================================
	// Luma stage A: brightness
	assign bright_sum = $signed({2'b00, pix_y}) + $signed({{3{bright_r[6]}}, bright_r});
	assign bright_clip = bright_sum[9] ? 8'h00 : (bright_sum[8] ? 8'hff : bright_sum[7:0]);

	// Column counter restarts with each line for the vertical filter
	assign col_in = line_start ? {LINE_AW{1'b0}} : col_r;

	always @(posedge sys_clk) begin
		if (reset) begin
			ya_r <= 8'h00;
			col_r <= {LINE_AW{1'b0}};
			col_a_r <= {LINE_AW{1'b0}};
		end else if (pix_valid) begin
			ya_r <= bright_clip;
			col_a_r <= col_in;
			col_r <= col_in + 1'b1;
		end
	end
	// ==========================================================
	// Luma stage B: contrast, gain in 1.7 unsigned format
	assign contrast_prod = ya_r * luma_contrast_gain_r;
	assign contrast_shift = contrast_prod[`PA_GAIN_FRAC+8:`PA_GAIN_FRAC];
	assign contrast_over = contrast_shift[8];
	assign contrast_clip = contrast_over ? 8'hff : contrast_shift[7:0];

	// Previous line's sample at this column; read happens as the new one is stored
	line_store #(
		.DEPTH(LINE_DEPTH),
		.AW(LINE_AW),
		.DW(8)
	) line_store_inst (
		.sys_clk(sys_clk),
		.en(pix_valid),
		.addr(col_a_r),
		.wr_data(contrast_clip),
		.rd_data(up0)
	);

	// Five-tap horizontal window and the matching samples from the line above
	always @(posedge sys_clk) begin
		if (reset) begin
			w0_r <= 8'h00;
			w1_r <= 8'h00;
			w2_r <= 8'h00;
			w3_r <= 8'h00;
			w4_r <= 8'h00;
			up1_r <= 8'h00;
			up2_r <= 8'h00;
		end else if (pix_valid) begin
			w0_r <= contrast_clip;
			w1_r <= w0_r;
			w2_r <= w1_r;
			w3_r <= w2_r;
			w4_r <= w3_r;
			up1_r <= up0;
			up2_r <= up1_r;
		end
	end
	// ==========================================================
	// Luma stage C: band split whose unity sum returns the centre sample
	assign low_sum = {3'h0, w0_r} + {2'h0, w1_r, 1'b0} + {2'h0, w2_r, 1'b0}
		+ {2'h0, w3_r, 1'b0} + {3'h0, w4_r};
	assign med_sum = {2'h0, w1_r} + {1'h0, w2_r, 1'b0} + {2'h0, w3_r};
	assign low_band = low_sum[10:3];
	assign med_band = med_sum[9:2];
	assign low_s = $signed({2'b00, low_band});
	assign mid_s = $signed({2'b00, med_band}) - $signed({2'b00, low_band});
	assign high_s = $signed({2'b00, w2_r}) - $signed({2'b00, med_band});
	// Vertical detail is the centre minus the two-line average
	assign vert_sum = {1'b0, w2_r} + {1'b0, up2_r};
	assign vhf_s = $signed({2'b00, w2_r}) - $signed({2'b00, vert_sum[8:1]});

	// Reserved vertical codes 01 and 10 act like 00 and add no vertical term; software must not use them
	assign sharp_total = band_gain(high_s, luma_band_sharpness_r[`PA_SHARP_HI_LSB+1:`PA_SHARP_HI_LSB])
		+ band_gain(mid_s, luma_band_sharpness_r[`PA_SHARP_MID_LSB+1:`PA_SHARP_MID_LSB])
		+ band_gain(low_s, luma_band_sharpness_r[`PA_SHARP_LOW_LSB+1:`PA_SHARP_LOW_LSB])
		- ((luma_band_sharpness_r[`PA_SHARP_VERT_LSB+1:`PA_SHARP_VERT_LSB] == `PA_GAIN_ZERO)
			? $signed({{5{vhf_s[9]}}, vhf_s}) : 15'sh0000);
	assign sharp_over = sharp_total[14] | (sharp_total[13:8] != 6'h00);
	assign sharp_clip = sharp_total[14] ? 8'h00 : (sharp_over ? 8'hff : sharp_total[7:0]);
	// ==========================================================
	// Chroma stage A: hue rotation of signed CbCr
	// Offset binary to two's complement: flip the top bit, then sign-extend it
	hue_rotator hue_rotator_inst (
		.sys_clk(sys_clk),
		.reset(reset),
		.en(pix_valid),
		.hue(chroma_hue_phase_r),
		.cb_in($signed({~pix_cb[7], ~pix_cb[7], pix_cb[6:0]})),
		.cr_in($signed({~pix_cr[7], ~pix_cr[7], pix_cr[6:0]})),
		.cb_out(cb_rot),
		.cr_out(cr_rot)
	);

	// Chroma stage B: saturation, same 1.7 format as contrast
	assign cb_prod = cb_rot * $signed({1'b0, chroma_saturation_gain_r});
	assign cr_prod = cr_rot * $signed({1'b0, chroma_saturation_gain_r});
	assign cb_sat = chroma_clip(cb_prod);
	assign cr_sat = chroma_clip(cr_prod);
	assign cb_over = chroma_over(cb_prod);
	assign cr_over = chroma_over(cr_prod);

	// Chroma delays keep pairing with the centre luma tap
	always @(posedge sys_clk) begin
		if (reset) begin
			cb_s_r <= 8'h80;
			cr_s_r <= 8'h80;
			cb_d1_r <= 8'h80;
			cr_d1_r <= 8'h80;
			cb_d2_r <= 8'h80;
			cr_d2_r <= 8'h80;
		end else if (pix_valid) begin
			cb_s_r <= cb_sat;
			cr_s_r <= cr_sat;
			cb_d1_r <= cb_s_r;
			cr_d1_r <= cr_s_r;
			cb_d2_r <= cb_d1_r;
			cr_d2_r <= cr_d1_r;
		end
	end
	// ==========================================================
	// Output stage; nothing leaves until the pipeline has been filled once
	always @(posedge sys_clk) begin
		if (reset) begin
			fill_r <= 3'h0;
			out_valid <= 1'b0;
			out_y <= 8'h00;
			out_cb <= 8'h80;
			out_cr <= 8'h80;
		end else begin
			out_valid <= pix_valid && (fill_r == `PA_LATENCY);
			if (pix_valid) begin
				if (fill_r != `PA_LATENCY)
					fill_r <= fill_r + 3'h1;
				out_y <= sharp_clip;
				out_cb <= cb_d2_r;
				out_cr <= cr_d2_r;
			end
		end
	end

endmodule // picture_adjust_controls

// ===== picture_adjust_defs.vh
// Register indices, field positions, reset values and fixed-point constants
`ifndef PICTURE_ADJUST_DEFS_VH
`define PICTURE_ADJUST_DEFS_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define PA_IDX_BRIGHT 3'h1
`define PA_IDX_CONTRAST 3'h2
`define PA_IDX_HUE 3'h3
`define PA_IDX_SHARP 3'h4
`define PA_IDX_SAT 3'h5
`define PA_IDX_STATUS 3'h6

// ==========================================================
// Reset values
`define PA_RST_BRIGHT 7'h00
`define PA_RST_CONTRAST 8'hbd
`define PA_RST_HUE 8'h00
`define PA_RST_SHARP 8'h00
`define PA_RST_SAT 8'h9d

// ==========================================================
// Sharpness field positions (low bit of each 2-bit field)
`define PA_SHARP_HI_LSB 6
`define PA_SHARP_MID_LSB 4
`define PA_SHARP_LOW_LSB 2
`define PA_SHARP_VERT_LSB 0

// Band gain codes
`define PA_GAIN_X1 2'h0
`define PA_GAIN_X2 2'h1
`define PA_GAIN_X4 2'h2
`define PA_GAIN_ZERO 2'h3

// ==========================================================
// Status bit positions
`define PA_STAT_LUMA_CLIP 0
`define PA_STAT_CHROMA_CLIP 1

// ==========================================================
// Fixed point: gains carry 7 fraction bits, rotation uses 14
`define PA_GAIN_FRAC 7
`define PA_TRIG_FRAC 14
// One quarter degree in radians, times 2^14, rounded (0.0043633 * 16384)
`define PA_HUE_STEP_Q14 9'h047
`define PA_COS_ONE 17'h0_4000
// Approximation of 1/6 as 43/256 for the cubic sine term
`define PA_SIXTH_NUM 8'h2b

// Pipeline depth in accepted samples
`define PA_LATENCY 3'h4

`endif

// ===== line_store.v
// Single-port line memory with registered read data, read before write
`timescale 1ns/1ns
module line_store #(
	parameter DEPTH = 1024,
	parameter AW = 10,
	parameter DW = 8
) (
	// Clock
	input wire sys_clk,
	// Access
	input wire en,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wr_data,
	output reg [DW-1:0] rd_data
);

	reg [DW-1:0] mem [0:DEPTH-1];

	// Old contents come out while the new sample lands in the same slot
	always @(posedge sys_clk) begin
		if (en) begin
			rd_data <= mem[addr];
			mem[addr] <= wr_data;
		end
	end

endmodule // line_store

// ===== hue_rotator.v
// Chroma phase rotator with small-angle sine and cosine approximations
`timescale 1ns/1ns
`include "picture_adjust_defs.vh"
module hue_rotator (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Sample advance
	input wire en,
	// Phase in quarter degrees, two's complement
	input wire [7:0] hue,
	// Signed chroma in and out
	input wire signed [8:0] cb_in,
	input wire signed [8:0] cr_in,
	output reg signed [10:0] cb_out,
	output reg signed [10:0] cr_out
);

	// ==========================================================
	// Angle and trig terms
	wire signed [23:0] ang_w;
	wire signed [47:0] ang2_w;
	wire signed [47:0] ang3_w;
	wire signed [47:0] cube_w;
	wire signed [16:0] sin_w;
	wire signed [16:0] cos_w;
	wire signed [27:0] cb_rot_w;
	wire signed [27:0] cr_rot_w;

	// Range stays within about 32 degrees, so the series is accurate enough
	assign ang_w = $signed(hue) * $signed(`PA_HUE_STEP_Q14);
	assign ang2_w = ang_w * ang_w;
	assign ang3_w = ang2_w * ang_w;
	assign cube_w = ((ang3_w >>> 28) * $signed({1'b0, `PA_SIXTH_NUM})) >>> 8;
	assign sin_w = ang_w[16:0] - cube_w[16:0];
	assign cos_w = $signed(`PA_COS_ONE) - ang2_w[31:15];

	// Zero phase gives cos of one and sin of zero, leaving chroma untouched
	assign cb_rot_w = cb_in * cos_w + cr_in * sin_w;
	assign cr_rot_w = cr_in * cos_w - cb_in * sin_w;

	// ==========================================================
	// Output registers
	always @(posedge sys_clk) begin
		if (reset) begin
			cb_out <= 11'h000;
			cr_out <= 11'h000;
		end else if (en) begin
			cb_out <= cb_rot_w[`PA_TRIG_FRAC+10:`PA_TRIG_FRAC];
			cr_out <= cr_rot_w[`PA_TRIG_FRAC+10:`PA_TRIG_FRAC];
		end
	end

endmodule // hue_rotator

// ===== picture_adjust_props.sv
// Port-level assertions for the picture adjustment block
`timescale 1ns/1ns
module picture_adjust_props (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Register bus
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	// Pixel stream
	input wire pix_valid,
	input wire out_valid,
	input wire [7:0] out_y,
	input wire [7:0] out_cb,
	input wire [7:0] out_cr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ==========================================================
	// Gain mirror, so reads are judged without peeking inside
	reg [7:0] ct_r;
	reg [7:0] hu_r;
	reg [7:0] sa_r;
	wire wr_take = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
	always @(posedge sys_clk) begin
		if (reset) begin
			ct_r <= 8'hbd;
			hu_r <= 8'h00;
			sa_r <= 8'h9d;
		end else if (wr_take) begin
			if (adr_i == 8'h08)
				ct_r <= dat_i[7:0];
			if (adr_i == 8'h0c)
				hu_r <= dat_i[7:0];
			if (adr_i == 8'h14)
				sa_r <= dat_i[7:0];
		end
	end
	// ==========================================================
	// Bus handshake and read data
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000) else $error("upper bits");
	unmapped_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i[7:5]) != 3'h0
		|-> dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	contrast_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h08
		|-> dat_o[7:0] == ct_r) else $error("contrast read wrong");
	hue_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h0c
		|-> dat_o[7:0] == hu_r) else $error("hue read wrong");
	sat_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h14
		|-> dat_o[7:0] == sa_r) else $error("saturation read wrong");
	// Data outputs move only on accepted samples; valid rises only after one
	valid_cause_a: assert property (out_valid |-> $past(pix_valid)) else $error("stray valid");
	out_hold_a: assert property (!$past(pix_valid) |-> $stable({out_y, out_cb, out_cr}))
		else $error("output moved without input");
endmodule // picture_adjust_props

// ===== picture_adjust_controls_test.sv
// Self-checking testbench for the picture adjustment block
`timescale 1ns/1ns
module picture_adjust_controls_test;
	// ==========================================================
	// Ports, counters and case table
	logic sys_clk, reset, cyc_i, stb_i, we_i, ack_o, pix_valid, line_start, out_valid;
	logic [7:0] adr_i, pix_y, pix_cb, pix_cr, out_y, out_cb, out_cr;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q;
	int num_errors, total_checks;
	typedef struct packed {
		logic [7:0] br, ct, hu, sh, sa, y, y2, cb, cr, ylo, yhi, blo, bhi, rlo, rhi;
	} row_t;
	row_t r;
	logic [7:0] regs [5];
	logic [7:0] rst_val [5] = '{8'h00, 8'hbd, 8'h00, 8'h00, 8'h9d};
	// Vertical field only ever gets 00 or 11 here
	row_t rows [17] = '{
		120'h00_8000_0080_6464_a858_6464_a8a8_5858, 120'h00_bd00_009d_6464_a880_9393_b1b1_8080,
		120'h3f_8000_0080_6464_8080_a3a3_8080_8080, 120'h40_8000_0080_6464_8080_2424_8080_8080,
		120'h00_ff00_00ff_c8c8_e41c_ffff_ffff_0000, 120'h00_8000_0c80_6464_8080_0000_8080_8080,
		120'h00_8000_0480_6464_8080_c8c8_8080_8080, 120'h00_8000_0880_6464_8080_ffff_8080_8080,
		120'h00_8000_0080_5078_8080_7878_8080_8080, 120'h00_8000_4080_5078_8080_8c8c_8080_8080,
		120'h00_8000_8080_5078_8080_b4b4_8080_8080, 120'h00_8000_c080_5078_8080_6464_8080_8080,
		120'h00_8000_3080_6464_8080_6464_8080_8080, 120'h00_8000_0380_c8c8_8080_9696_8080_8080,
		120'h00_807f_0080_6464_80c0_6464_9ea4_b3b9, 120'h00_8080_0080_6464_80c0_6464_5b61_b3b9,
		120'h00_8000_4080_7850_8080_3c3c_8080_8080};

	picture_adjust_controls picture_adjust_controls_inst (.sys_clk(sys_clk), .reset(reset),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .pix_valid(pix_valid), .line_start(line_start),
		.pix_y(pix_y), .pix_cb(pix_cb), .pix_cr(pix_cr), .out_valid(out_valid),
		.out_y(out_y), .out_cb(out_cb), .out_cr(out_cr));

	// 250 MHz clock
	initial begin
		sys_clk = 0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Hang guard: whole run needs under eight hundred cycles
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	// One classic cycle; waits on ack, no fixed latency assumed
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= {24'h00_0000, d};
		do @(posedge sys_clk); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Ten samples on one line, even and odd luma may differ
	task automatic feed(input logic [7:0] y, input logic [7:0] y2, input logic [7:0] cb,
		input logic [7:0] cr);
		for (int i = 0; i < 10; i++) begin
			pix_valid <= 1'b1;
			line_start <= (i == 0);
			pix_y <= i[0] ? y2 : y;
			pix_cb <= cb;
			pix_cr <= cr;
			@(posedge sys_clk);
		end
		pix_valid <= 1'b0;
		line_start <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic reset_check();
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		check(out_y, 8'h00, "luma after reset");
		check(out_cb, 8'h80, "cb after reset");
		for (int k = 0; k < 5; k++) begin
			bus(1'b0, 8'h04 + 8'(4 * k), 8'h00, 4'hf);
			check(q[7:0], rst_val[k], "reset value");
		end
		$display("test reset done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		{cyc_i, stb_i, we_i, pix_valid, line_start} = 5'h00;
		{adr_i, pix_y, pix_cb, pix_cr} = 32'h0000_8080;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		reset = 1'b1;
		reset_check();
		foreach (rows[i]) begin
			r = rows[i];
			regs = '{r.br, r.ct, r.hu, r.sh, r.sa};
			for (int k = 0; k < 5; k++) begin
				bus(1'b1, 8'h04 + 8'(4 * k), regs[k], 4'h1);
				bus(1'b0, 8'h04 + 8'(4 * k), 8'h00, 4'hf);
				check(q[7:0], regs[k], "readback");
			end
			feed(r.y, r.y2, r.cb, r.cr);
			check(out_y >= r.ylo && out_y <= r.yhi, 1'b1, "luma");
			check(out_cb >= r.blo && out_cb <= r.bhi, 1'b1, "cb");
			check(out_cr >= r.rlo && out_cr <= r.rhi, 1'b1, "cr");
			$display("test row %0d done", i);
		end
		// Lane zero disabled: write must not land
		bus(1'b1, 8'h08, 8'h11, 4'he);
		bus(1'b0, 8'h08, 8'h00, 4'hf);
		check(q[7:0], 8'h80, "masked write");
		// Unmapped and misaligned places read zero
		bus(1'b1, 8'h20, 8'h5a, 4'h1);
		bus(1'b0, 8'h20, 8'h00, 4'hf);
		check(q, 32'h0000_0000, "unmapped read");
		bus(1'b0, 8'h09, 8'h00, 4'hf);
		check(q, 32'h0000_0000, "misaligned read");
		// Clip flags are sticky after the saturating rows; clear one bit at a time
		bus(1'b0, 8'h18, 8'h00, 4'hf);
		check(q[7:0], 8'h03, "clip flags");
		bus(1'b1, 8'h18, 8'h01, 4'h1);
		bus(1'b0, 8'h18, 8'h00, 4'hf);
		check(q[7:0], 8'h02, "luma flag clear");
		bus(1'b1, 8'h18, 8'h02, 4'h1);
		bus(1'b0, 8'h18, 8'h00, 4'hf);
		check(q[7:0], 8'h00, "chroma flag clear");
		$display("test bus corners done");
		reset_check();
		// Strobe stays low for four samples after reset, pulses with the fifth, then drops once samples stop
		pix_valid <= 1'b1;
		line_start <= 1'b1;
		for (int n = 0; n < 6; n++) begin
			@(posedge sys_clk);
			pix_valid <= (n < 4);
			line_start <= 1'b0;
			@(negedge sys_clk);
			check(out_valid, n == 4, "output strobe");
		end
		$display("test strobe done");
		report_and_stop();
	end
endmodule // picture_adjust_controls_test

bind picture_adjust_controls picture_adjust_props picture_adjust_props_inst (
	.sys_clk(sys_clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.pix_valid(pix_valid), .out_valid(out_valid), .out_y(out_y), .out_cb(out_cb),
	.out_cr(out_cr));
